// ### dfp_pkg.sv
package dfp_pkg;

	// Pin inputs of the prescaler, all asynchronous to clk
	typedef struct packed {
		logic src_clk;
		logic cnt_inhibit;
		logic stage_clear;
	} dfp_pins_t;

	// Complementary divided output pair
	typedef struct packed {
		logic q_true;
		logic q_comp;
	} dfp_out_t;

	localparam logic STAGE_RESET_VAL = 1'b0;
	localparam dfp_pins_t PINS_RESET_VAL = 3'h0;
	localparam dfp_out_t OUT_RESET_VAL = 2'h1;
	localparam int unsigned SYNC_STAGES = 2;

	// Stage two toggles once per this many qualified input edges
	localparam int unsigned EDGES_PER_HALF = 2;

endpackage

// ### dfp_toggle.sv
`timescale 1ns/1ns
module dfp_toggle (
	input wire logic clk,
	input wire logic resetn,
	input wire logic toggle,
	input wire logic clear,
	output logic q
);

	// Clear beats toggle, as in a direct-reset toggle flip-flop
	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= dfp_pkg::STAGE_RESET_VAL;
		end else if (clear) begin
			q <= dfp_pkg::STAGE_RESET_VAL;
		end else if (toggle) begin
			q <= ~q;
		end
	end

endmodule

// ### dfp_prescaler.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Two cascaded toggle stages divide by four
// - True and complement outputs from stage two
// - Clear acts only with clock or enable high
// - Enable gates the input clock, stages hold
module dfp_prescaler (
	input wire logic clk,
	input wire logic resetn,
	input wire dfp_pkg::dfp_pins_t pins,
	output dfp_pkg::dfp_out_t out_q
);

	dfp_pkg::dfp_pins_t sync1_q;
	dfp_pkg::dfp_pins_t sync2_q;
	logic src_prev_q;
	logic src_rise;
	logic count_ok;
	logic stage_clr;
	logic tog1;
	logic tog2;
	logic stage1_q;
	logic stage2_q;
	dfp_pkg::dfp_out_t out_d;

	// Pins are asynchronous; two flops before any logic looks at them
	// Costs about four clocks from pin to output
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1_q <= dfp_pkg::PINS_RESET_VAL;
			sync2_q <= dfp_pkg::PINS_RESET_VAL;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	// Edge history for the source clock, from the second flop only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= sync2_q.src_clk;
		end
	end

	// Idle-low history: a pin already high at release counts once
	assign src_rise = sync2_q.src_clk & ~src_prev_q;

	assign count_ok = ~sync2_q.cnt_inhibit;

	assign stage_clr = sync2_q.stage_clear
		& (sync2_q.src_clk | sync2_q.cnt_inhibit);

	assign tog1 = src_rise & count_ok;

	assign tog2 = tog1 & stage1_q;

	dfp_toggle u_stage1 (
		.clk(clk),
		.resetn(resetn),
		.toggle(tog1),
		.clear(stage_clr),
		.q(stage1_q)
	);

	dfp_toggle u_stage2 (
		.clk(clk),
		.resetn(resetn),
		.toggle(tog2),
		.clear(stage_clr),
		.q(stage2_q)
	);

	always_comb begin
		out_d.q_true = stage2_q;
		out_d.q_comp = ~stage2_q;
	end

	// registered pair
	// Registered so the pins never see a glitch from the decode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_q <= dfp_pkg::OUT_RESET_VAL;
		end else begin
			out_q <= out_d;
		end
	end

	// Helper: qualified edges seen since stage two last moved
	logic [1:0] half_cnt_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			half_cnt_q <= 2'h0;
		end else if (stage_clr || tog2) begin
			half_cnt_q <= 2'h0;
		end else if (tog1) begin
			half_cnt_q <= half_cnt_q + 2'h1;
		end
	end

	// Checks sleep in reset; the reset check opts out on its own
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_stage1_toggle;
		tog1 && !stage_clr |=> stage1_q != $past(stage1_q);
	endproperty
	a_stage1_toggle: assert property (p_stage1_toggle)
		else $error("stage one missed a qualified edge");

	property p_stage2_cascade;
		!stage_clr ##1 $changed(stage2_q) |-> $fell(stage1_q);
	endproperty
	a_stage2_cascade: assert property (p_stage2_cascade)
		else $error("stage two moved without stage one falling");

	property p_half_period;
		tog1 && !stage_clr
			&& (half_cnt_q == 2'(dfp_pkg::EDGES_PER_HALF - 1))
			|=> $changed(stage2_q);
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("stage two half period is not two edges");

	property p_out_pair;
		out_q.q_true != out_q.q_comp;
	endproperty
	a_out_pair: assert property (p_out_pair)
		else $error("output pair not complementary");

	property p_out_follow;
		##1 out_q.q_true == $past(stage2_q);
	endproperty
	a_out_follow: assert property (p_out_follow)
		else $error("true output does not follow stage two");

	property p_clear;
		stage_clr |=> !stage1_q && !stage2_q ##1 !out_q.q_true;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not empty both stages");

	property p_clear_ignored;
		sync2_q.stage_clear && !sync2_q.src_clk && !sync2_q.cnt_inhibit
			|=> $stable(stage1_q) && $stable(stage2_q);
	endproperty
	a_clear_ignored: assert property (p_clear_ignored)
		else $error("clear acted with clock and enable low");

	property p_inhibit_hold;
		sync2_q.cnt_inhibit && !sync2_q.stage_clear
			|=> $stable(stage1_q) && $stable(stage2_q);
	endproperty
	a_inhibit_hold: assert property (p_inhibit_hold)
		else $error("stages moved while inhibited");

	property p_low_enable_counts;
		src_rise && !sync2_q.cnt_inhibit && !stage_clr
			|=> $changed(stage1_q);
	endproperty
	a_low_enable_counts: assert property (p_low_enable_counts)
		else $error("low enable did not count");

	property p_tester_seq;
		tog1 && !stage_clr && !stage1_q
			|=> stage1_q && $stable(stage2_q);
	endproperty
	a_tester_seq: assert property (p_tester_seq)
		else $error("first edge after clear moved stage two");

	property p_half_track;
		half_cnt_q == {1'b0, stage1_q};
	endproperty
	a_half_track: assert property (p_half_track)
		else $error("stage one is not the parity of counted edges");

	property p_stage1_hold;
		!tog1 && !stage_clr |=> $stable(stage1_q);
	endproperty
	a_stage1_hold: assert property (p_stage1_hold)
		else $error("stage one moved without a qualified edge");

	property p_stage2_hold;
		!tog2 && !stage_clr |=> $stable(stage2_q);
	endproperty
	a_stage2_hold: assert property (p_stage2_hold)
		else $error("stage two moved without a cascade");

	property p_comp_follow;
		##1 out_q.q_comp == !$past(stage2_q);
	endproperty
	a_comp_follow: assert property (p_comp_follow)
		else $error("complement output does not follow stage two");

	property p_reset_clear;
		disable iff (1'b0)
		!resetn |=> !stage1_q && !stage2_q
			&& (out_q == dfp_pkg::OUT_RESET_VAL);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("reset did not empty stages and outputs");

	// Main scenarios: tester sequence, division, gating, ignored clear
	c_tester_seq: cover property (stage_clr ##1 !stage_clr ##[1:60] tog2);
	c_clear_seen: cover property (stage_clr ##1 tog1 ##[1:20] tog1);
	c_stage2_rise: cover property ($rose(stage2_q));
	c_inhibit_edge: cover property (src_rise && sync2_q.cnt_inhibit);
	c_clear_ignored: cover property (sync2_q.stage_clear
		&& !sync2_q.src_clk && !sync2_q.cnt_inhibit);

endmodule

// ### dfp_source.sv
`timescale 1ns/1ns
module dfp_source (
	input wire logic clk,
	output logic src_clk
);
	initial src_clk = 1'b0;
	// Four cycles a phase, above the sync minimum
	task automatic level(input logic v);
		@(posedge clk) #1 src_clk <= v;
		repeat (3) @(posedge clk);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			level(1'b1);
			level(1'b0);
		end
	endtask
endmodule

// ### dfp_prescaler_bench.sv
`timescale 1ns/1ns
module dfp_prescaler_bench;
	logic clk;
	logic resetn;
	logic inh;
	logic clr;
	logic src;
	dfp_pkg::dfp_pins_t pins;
	dfp_pkg::dfp_out_t q;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	assign pins = {src, inh, clr};
	always #2 clk = ~clk;
	dfp_source src_m (.clk(clk), .src_clk(src));
	dfp_prescaler uut (.clk(clk), .resetn(resetn), .pins(pins), .out_q(q));
	task automatic chk(input dfp_pkg::dfp_out_t s, input dfp_pkg::dfp_out_t e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic drv(input logic c, input logic i);
		@(posedge clk) #1;
		clr = c;
		inh = i;
	endtask
	// Pin to output is about four edges
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic sc_count;
		src_m.level(1'b1);
		drv(1'b1, 1'b0);
		settle();
		chk(q, 2'h1);
		drv(1'b0, 1'b0);
		src_m.level(1'b0);
		src_m.pulse(1);
		settle();
		chk(q, 2'h1);
		src_m.pulse(1);
		settle();
		chk(q, 2'h2);
		src_m.pulse(2);
		settle();
		chk(q, 2'h1);
		src_m.pulse(2);
		settle();
		chk(q, 2'h2);
	endtask
	task automatic sc_gate;
		drv(1'b0, 1'b1);
		src_m.pulse(2);
		settle();
		chk(q, 2'h2);
	endtask
	task automatic sc_clear;
		drv(1'b1, 1'b0);
		settle();
		chk(q, 2'h2);
		drv(1'b1, 1'b1);
		settle();
		chk(q, 2'h1);
		drv(1'b0, 1'b0);
	endtask
	task automatic sc_reset;
		src_m.pulse(2);
		settle();
		chk(q, 2'h2);
		@(posedge clk) #1 resetn = 1'b0;
		repeat (4) @(posedge clk);
		#1 resetn = 1'b1;
		chk(q, dfp_pkg::OUT_RESET_VAL);
		src_m.pulse(2);
		settle();
		chk(q, 2'h2);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		inh = 1'b0;
		clr = 1'b0;
		repeat (20) @(posedge clk);
		#1 resetn = 1'b1;
		chk(q, dfp_pkg::OUT_RESET_VAL);
		sc_count();
		sc_gate();
		sc_clear();
		sc_reset();
		report_and_stop();
	end
endmodule
